// File: core/eps_status.sv
// Probe status and control block with a classic Wishbone register slave.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module eps_status #(
   parameter int unsigned TIMEOUT_CYCLES = eps_pkg::TIMEOUT_CYC,
   parameter logic [1:0]  PROBE_UNIT     = 2'h0
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Probe processor state
   input  wire logic        emulating_i,
   input  wire logic        protected_mode_i,
   // Ready sources
   input  wire logic        mem_ready_i,
   input  wire logic        proto_ready_i,
   output logic             cpu_ready_o,
   // Activity for the timeouts
   input  wire logic        bus_active_i,
   input  wire logic        mem_access_i,
   input  wire logic        io_access_i,
   input  wire logic        coproc_access_i,
   output logic             emu_timeout_o,
   // Coprocessor and hold lines
   input  wire logic        coproc_request_line_i,
   input  wire logic        coproc_ack_line_i,
   input  wire logic        hold_req_i,
   input  wire logic        hold_grant_line_i,
   output logic             coproc_run_o,
   output logic             coproc_request_line_o,
   output logic             coproc_ack_line_o,
   output logic             hold_req_o,
   output logic             hold_grant_line_o,
   // External reset
   input  wire logic        proto_reset_i,
   output logic             probe_reset_o,
   // Trace capture
   input  wire logic        exec_info_i,
   input  wire logic        bus_cycle_i,
   output logic             trace_exec_wr_o,
   output logic             trace_bus_wr_o,
   // Shared pin sources and pins
   input  wire logic        addr_latch_i,
   input  wire logic        write_strobe_i,
   input  wire logic        read_strobe_i,
   input  wire logic        queue_state_line0_i,
   input  wire logic        queue_state_line1_i,
   input  wire logic        queue_state_mode_line_i,
   output logic      [2:0]  shared_pins_o
);
   import eps_pkg::*;

   logic [CTL_W-1:0]    ctrl_q;
   logic [N_TIMERS-1:0] flags_q;
   logic [N_TIMERS-1:0] flags_d;
   logic [N_TIMERS-1:0] expire;
   logic [N_TIMERS-1:0] run;
   logic [2:0]          unit_q;
   logic                req;
   logic                wr_stb;
   logic                allowed;

   // ==========================================================================
   // Settings decoded from the control register
   // ==========================================================================
   logic       combined_ready_sel;
   logic       bus_idle_timeout_en;
   logic       mem_access_timeout_en;
   logic       io_access_timeout_en;
   logic       coproc_hang_timeout_en;
   logic       coproc_enable;
   logic [1:0] coproc_run_mode;
   logic       external_reset_en;
   logic       trace_bus_cycles_en;
   logic       queue_status_pin_sel;

   assign combined_ready_sel     = ctrl_q[B_COMBINED_RDY];
   assign bus_idle_timeout_en    = ctrl_q[B_BUS_IDLE_TO];
   assign mem_access_timeout_en  = ctrl_q[B_MEM_TO];
   assign io_access_timeout_en   = ctrl_q[B_IO_TO];
   assign coproc_hang_timeout_en = ctrl_q[B_HANG_TO];
   assign coproc_enable          = ctrl_q[B_COPROC_EN];
   assign coproc_run_mode        = ctrl_q[B_RUN_MODE_HI:B_RUN_MODE_LO];
   assign external_reset_en      = ctrl_q[B_EXT_RST_EN];
   assign trace_bus_cycles_en    = ctrl_q[B_TRACE_BUS];
   assign queue_status_pin_sel   = ctrl_q[B_QUEUE_STATUS_PIN_SEL_SEL];

   // ==========================================================================
   // Wishbone handshake
   // ==========================================================================
   // Ack is registered and falls after one cycle; a write lands at the
   // edge where the master samples ack, so it never runs ahead of ack.
   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= req;
      end
   end

   // ==========================================================================
   // Control register
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
      end else if (ce_i && wr_stb && wb_adr_i == ADR_CTRL) begin
         if (wb_sel_i[0]) begin
            ctrl_q[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_q[CTL_W-1:8] <= wb_dat_i[CTL_W-1:8];
         end
      end
   end

   // ==========================================================================
   // Unit selection
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unit_q <= '0;
      end else if (ce_i && wr_stb && wb_adr_i == ADR_UNIT && wb_sel_i[0]) begin
         unit_q <= wb_dat_i[2:0];
      end
   end

   // ==========================================================================
   // Read data
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (ce_i && req) begin
         wb_dat_o <= '0;
         unique case (wb_adr_i)
            ADR_CTRL: begin
               wb_dat_o[CTL_W-1:0] <= ctrl_q;
            end
            ADR_STATUS: begin
               wb_dat_o[7:0]         <= PROBE_KIND;
               wb_dat_o[B_EXEC_MODE] <= protected_mode_i;
               wb_dat_o[B_EMULATING] <= emulating_i;
            end
            ADR_FLAGS: begin
               wb_dat_o[N_TIMERS-1:0] <= flags_q;
            end
            ADR_UNIT: begin
               wb_dat_o[2:0] <= unit_q;
            end
            ADR_REPORT: begin
               // This probe supplies values when selected or when the all-units bit is set; other units read zero.
               if (unit_q[B_UNIT_ALL] || unit_q[1:0] == PROBE_UNIT) begin
                  wb_dat_o[CTL_W-1:0] <= ctrl_q;
               end
            end
            default: begin
               wb_dat_o <= '0;
            end
         endcase
      end
   end

   // ==========================================================================
   // Timeouts
   // ==========================================================================
   // Timeouts only count while a program is emulating.
   assign run[T_BUS]  = emulating_i && bus_idle_timeout_en && !bus_active_i;
   assign run[T_MEM]  = emulating_i && mem_access_timeout_en && mem_access_i;
   assign run[T_IO]   = emulating_i && io_access_timeout_en && io_access_i;
   assign run[T_HANG] = emulating_i && coproc_hang_timeout_en
                        && coproc_access_i;

   for (genvar g = 0; g < N_TIMERS; g++) begin : g_timer
      eps_timer #(
         .LIMIT    (TIMEOUT_CYCLES)
      ) u_timer (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .ce_i     (ce_i),
         .run_i    (run[g]),
         .expire_o (expire[g])
      );
   end

   // Sticky flags clear by writing ones; a new expiry in the same cycle wins.
   always_comb begin
      flags_d = flags_q;
      if (wr_stb && wb_adr_i == ADR_FLAGS && wb_sel_i[0]) begin
         flags_d = flags_d & ~wb_dat_i[N_TIMERS-1:0];
      end
      flags_d = flags_d | expire;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q       <= '0;
         emu_timeout_o <= 1'b0;
      end else if (ce_i) begin
         flags_q       <= flags_d;
         emu_timeout_o <= |flags_d;
      end
   end

   // ==========================================================================
   // Ready selection
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_ready_o <= 1'b0;
      end else if (ce_i) begin
         if (combined_ready_sel) begin
            cpu_ready_o <= mem_ready_i && proto_ready_i;
         end else begin
            cpu_ready_o <= mem_ready_i;
         end
      end
   end

   // ==========================================================================
   // Coprocessor gating
   // ==========================================================================
   // Illegal mode codes are treated as never allowed rather than guessed.
   assign allowed = coproc_enable &&
                    ((coproc_run_mode == RUN_EMU_ONLY && emulating_i) ||
                     coproc_run_mode == RUN_ALWAYS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         coproc_run_o          <= 1'b0;
         coproc_request_line_o <= 1'b0;
         coproc_ack_line_o     <= 1'b0;
         hold_req_o            <= 1'b0;
         hold_grant_line_o     <= 1'b0;
      end else if (ce_i) begin
         coproc_run_o          <= allowed;
         coproc_request_line_o <= allowed && coproc_request_line_i;
         coproc_ack_line_o     <= allowed && coproc_ack_line_i;
         hold_req_o            <= allowed && hold_req_i;
         hold_grant_line_o     <= allowed && hold_grant_line_i;
      end
   end

   // ==========================================================================
   // External reset, trace capture and shared pins
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         probe_reset_o <= 1'b0;
      end else if (ce_i) begin
         probe_reset_o <= emulating_i && external_reset_en
                          && proto_reset_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trace_exec_wr_o <= 1'b0;
         trace_bus_wr_o  <= 1'b0;
      end else if (ce_i) begin
         trace_exec_wr_o <= exec_info_i;
         trace_bus_wr_o  <= trace_bus_cycles_en && bus_cycle_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shared_pins_o <= '0;
      end else if (ce_i) begin
         if (queue_status_pin_sel) begin
            shared_pins_o <= {queue_state_mode_line_i, queue_state_line1_i,
                              queue_state_line0_i};
         end else begin
            shared_pins_o <= {read_strobe_i, write_strobe_i,
                              addr_latch_i};
         end
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_combined;
      ce_i && combined_ready_sel;
   endsequence

   sequence s_emu_reset;
      ce_i && emulating_i && proto_reset_i;
   endsequence

   chk_ready_and: assert property (
      s_combined |=> cpu_ready_o == ($past(mem_ready_i) && $past(proto_ready_i)))
      else $error("combined ready is wrong");
   chk_ready_mapped: assert property (
      ce_i && !combined_ready_sel |=> cpu_ready_o == $past(mem_ready_i))
      else $error("mapped ready is wrong");
   chk_reset_enabled: assert property (
      s_emu_reset ##0 external_reset_en |=> probe_reset_o)
      else $error("enabled external reset lost");
   chk_reset_interrog: assert property (
      ce_i && !emulating_i |=> !probe_reset_o)
      else $error("reset passed in interrogation");
   chk_trace_bus: assert property (
      ce_i && !trace_bus_cycles_en |=> !trace_bus_wr_o)
      else $error("bus trace stored while off");
   chk_trace_both: assert property (
      ce_i && trace_bus_cycles_en && bus_cycle_i && exec_info_i
      |=> trace_bus_wr_o && trace_exec_wr_o)
      else $error("trace lost with bus tracing on");
   chk_pins_queue: assert property (
      ce_i && queue_status_pin_sel |=>
      shared_pins_o == $past({queue_state_mode_line_i, queue_state_line1_i,
                              queue_state_line0_i}))
      else $error("queue pins wrong");
   chk_pins_std: assert property (
      ce_i && !queue_status_pin_sel |=>
      shared_pins_o == $past({read_strobe_i, write_strobe_i, addr_latch_i}))
      else $error("standard pins wrong");
   chk_coproc_mode: assert property (
      ce_i && coproc_enable && coproc_run_mode == RUN_EMU_ONLY && !emulating_i
      |=> !coproc_run_o && !hold_grant_line_o)
      else $error("coprocessor ran outside emulation");
   chk_coproc_off: assert property (
      ce_i && !coproc_enable |=> !coproc_run_o && !coproc_request_line_o)
      else $error("coprocessor active while disabled");
   chk_flag_sticky: assert property (
      ce_i && expire[T_MEM] |=> flags_q[T_MEM] ##1 emu_timeout_o || !ce_i)
      else $error("timeout flag not set");
   chk_ack_once: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

endmodule : eps_status

// File: pkg/eps_pkg.sv
// Package with the register map, field layout and timing of the probe status block.
package eps_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned TIMEOUT_MS   = 1000;
   // A timeout fires only after the access has lasted longer than this count.
   localparam int unsigned TIMEOUT_CYC  = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int unsigned CNT_W        = 25;

   // ==========================================================================
   // Register offsets (byte addresses)
   // ==========================================================================
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_FLAGS  = 8'h08;
   localparam logic [7:0] ADR_UNIT   = 8'h0c;
   localparam logic [7:0] ADR_REPORT = 8'h10;

   // ==========================================================================
   // Control register fields
   // ==========================================================================
   localparam int CTL_W          = 11;
   localparam int B_COMBINED_RDY = 0;
   localparam int B_BUS_IDLE_TO  = 1;
   localparam int B_MEM_TO       = 2;
   localparam int B_IO_TO        = 3;
   localparam int B_HANG_TO      = 4;
   localparam int B_COPROC_EN    = 5;
   localparam int B_RUN_MODE_LO  = 6;
   localparam int B_RUN_MODE_HI  = 7;
   localparam int B_EXT_RST_EN   = 8;
   localparam int B_TRACE_BUS    = 9;
   localparam int B_QUEUE_STATUS_PIN_SEL_SEL    = 10;
   localparam logic [CTL_W-1:0] CTRL_RST = 11'h37e;

   // Run mode codes; 0 and 3 are illegal and block the coprocessor.
   localparam logic [1:0] RUN_EMU_ONLY = 2'h1;
   localparam logic [1:0] RUN_ALWAYS   = 2'h2;

   // ==========================================================================
   // Status, flag and unit fields
   // ==========================================================================
   localparam int B_EXEC_MODE  = 8;
   localparam int B_EMULATING  = 9;
   localparam int N_TIMERS     = 4;
   localparam int T_BUS        = 0;
   localparam int T_MEM        = 1;
   localparam int T_IO         = 2;
   localparam int T_HANG       = 3;
   localparam int B_UNIT_ALL   = 2;
   // Probe kind code; the value is arbitrary.
   localparam logic [7:0] PROBE_KIND = 8'h5a;

endpackage : eps_pkg

// File: core/eps_timer.sv
// One-second access or inactivity timer with a single expiry pulse per episode.
`timescale 1ns/1ps
module eps_timer #(
   parameter int unsigned LIMIT = eps_pkg::TIMEOUT_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic run_i,
   output logic      expire_o
);
   import eps_pkg::*;

   localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

   logic [CNT_W-1:0] cnt_q;
   logic             fired_q;

   // ==========================================================================
   // Counter
   // ==========================================================================
   // The count is dropped as soon as the watched condition ends, so it
   // measures one uninterrupted episode only.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q    <= '0;
         fired_q  <= 1'b0;
         expire_o <= 1'b0;
      end else if (ce_i) begin
         expire_o <= 1'b0;
         if (!run_i) begin
            cnt_q   <= '0;
            fired_q <= 1'b0;
         end else if (!fired_q) begin
            if (cnt_q == LIM) begin
               fired_q  <= 1'b1;
               expire_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   chk_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !run_i |=> cnt_q == '0 && !fired_q)
      else $error("timer did not restart");
   chk_timer_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(expire_o) |-> $past(run_i) && $past(cnt_q) == LIM)
      else $error("timer expired without a full episode");

endmodule : eps_timer

// File: sim/eps_proto_model.sv
// Prototype target model driving ready, reset and coprocessor lines.
`timescale 1ns/1ps
module eps_proto_model (
   input  wire logic       clk_i,
   input  wire logic       en_i,
   output logic            ready_o,
   output logic            reset_o,
   output logic [3:0]      lines_o
);
   // ==================================================================
   // Prototype activity
   // ==================================================================
   initial begin
      ready_o = 1'b1;
      reset_o = 1'b0;
      lines_o = 4'h0;
   end

   // Ready is withheld now and then so that the gating of ready shows.
   always @(posedge clk_i) begin
      if (en_i) begin
         ready_o <= ($urandom % 3) != 0;
         reset_o <= 1'($urandom);
         lines_o <= 4'($urandom);
      end else begin
         ready_o <= 1'b1;
         reset_o <= 1'b0;
         lines_o <= 4'h0;
      end
   end
endmodule : eps_proto_model

// File: sim/testbench.sv
// Self-checking testbench of the probe status and control block.
`timescale 1ns/1ps
module testbench;
   import eps_pkg::*;
   localparam int unsigned TO = 5;
   logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, raw_lines, e_gl;
   wire  [3:0] gl_o;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic emulating_i, protected_mode_i, mem_ready_i, proto_ready_i;
   logic cpu_ready_o, bus_active_i, mem_access_i, io_access_i;
   logic coproc_access_i, emu_timeout_o, coproc_run_o, proto_reset_i;
   logic probe_reset_o, exec_info_i, bus_cycle_i, trace_exec_wr_o;
   logic trace_bus_wr_o, addr_latch_i, write_strobe_i, read_strobe_i;
   logic ql0, ql1, qlm, rnd_en, v_q, e_rdy, e_run, e_rst, e_tx, e_tb;
   logic e_cp, e_en;
   logic [2:0] shared_pins_o, e_pins;
   logic [10:0] ctrl_m;
   int err_count, samples_checked;
   logic [31:0] read_data[$];

   eps_status #(.TIMEOUT_CYCLES(TO), .PROBE_UNIT(2'h0)) dut (
      .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .emulating_i,
      .protected_mode_i, .mem_ready_i, .proto_ready_i, .cpu_ready_o,
      .bus_active_i, .mem_access_i, .io_access_i, .coproc_access_i,
      .emu_timeout_o, .coproc_request_line_i(raw_lines[3]),
      .coproc_ack_line_i(raw_lines[2]), .hold_req_i(raw_lines[1]),
      .hold_grant_line_i(raw_lines[0]), .coproc_run_o,
      .coproc_request_line_o(gl_o[3]), .coproc_ack_line_o(gl_o[2]),
      .hold_req_o(gl_o[1]), .hold_grant_line_o(gl_o[0]), .proto_reset_i,
      .probe_reset_o, .exec_info_i, .bus_cycle_i, .trace_exec_wr_o,
      .trace_bus_wr_o, .addr_latch_i, .write_strobe_i, .read_strobe_i,
      .queue_state_line0_i(ql0), .queue_state_line1_i(ql1),
      .queue_state_mode_line_i(qlm), .shared_pins_o);

   eps_proto_model proto (.clk_i, .en_i(!rst_i), .ready_o(proto_ready_i),
      .reset_o(proto_reset_i), .lines_o(raw_lines));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ==================================================================
   // Checking and bus tasks
   // ==================================================================
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // Bounded wait: a slave that never acknowledges ends the run.
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         test_done();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (we && a == ADR_CTRL) ctrl_m = d[10:0];
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      read_data.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   task automatic cond(input int t, input logic on);
      case (t)
         0: bus_active_i <= !on;
         1: mem_access_i <= on;
         2: io_access_i <= on;
         default: coproc_access_i <= on;
      endcase
   endtask : cond

   // ==================================================================
   // Stimulus and monitor
   // ==================================================================
   always @(posedge clk_i) begin
      if (rnd_en) begin
         {mem_ready_i, emulating_i, protected_mode_i, exec_info_i,
          bus_cycle_i, addr_latch_i, write_strobe_i, read_strobe_i,
          ql0, ql1, qlm, bus_active_i, mem_access_i, io_access_i,
          coproc_access_i} <= 15'($urandom);
      end
   end

   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (read_data.size() == 0) chk("unasked read", 32'h0, 32'h1);
         else chk("read data", read_data.pop_front(), wb_dat_o);
      end
      if (v_q) begin
         chk("ready", 32'(e_rdy), 32'(cpu_ready_o));
         chk("coproc run", 32'(e_run), 32'(coproc_run_o));
         chk("lines", 32'(e_gl), 32'(gl_o));
         chk("probe reset", 32'(e_rst), 32'(probe_reset_o));
         chk("trace exec", 32'(e_tx), 32'(trace_exec_wr_o));
         chk("trace bus", 32'(e_tb), 32'(trace_bus_wr_o));
         chk("pins", 32'(e_pins), 32'(shared_pins_o));
      end
      v_q = !rst_i && rnd_en && !wb_cyc_i;
      e_rdy = mem_ready_i & (proto_ready_i | !ctrl_m[B_COMBINED_RDY]);
      e_cp = (ctrl_m[7:6] == RUN_EMU_ONLY && emulating_i) ||
             ctrl_m[7:6] == RUN_ALWAYS;
      e_en = ctrl_m[B_COPROC_EN];
      e_run = e_en & e_cp;
      e_gl = raw_lines & {4{e_run}};
      e_rst = ctrl_m[B_EXT_RST_EN] & emulating_i & proto_reset_i;
      e_tx = exec_info_i;
      e_tb = ctrl_m[B_TRACE_BUS] & bus_cycle_i;
      e_pins = ctrl_m[B_QUEUE_STATUS_PIN_SEL_SEL] ? {qlm, ql1, ql0} :
               {read_strobe_i, write_strobe_i, addr_latch_i};
   end

   initial begin
      r = $urandom(32'h1661);
      {rst_i, ce_i, bus_active_i, emulating_i} = 4'hf;
      {wb_cyc_i, wb_stb_i, wb_we_i, protected_mode_i, mem_ready_i} = 5'h0;
      {mem_access_i, io_access_i, coproc_access_i, exec_info_i} = 4'h0;
      {bus_cycle_i, addr_latch_i, write_strobe_i, read_strobe_i} = 4'h0;
      {ql0, ql1, qlm, rnd_en, v_q} = 5'h0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      ctrl_m = CTRL_RST;
      err_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_CTRL, 32'(CTRL_RST));
      rd(ADR_STATUS, {22'h0, 2'b10, PROBE_KIND});
      @(posedge clk_i) protected_mode_i <= 1'b1;
      rd(ADR_STATUS, {22'h0, 2'b11, PROBE_KIND});
      xfer(1'b1, ADR_STATUS, 32'h0);
      rd(ADR_STATUS, {22'h0, 2'b11, PROBE_KIND});
      rd(8'h20, 32'h0);
      xfer(1'b1, ADR_UNIT, 32'h2);
      rd(ADR_UNIT, 32'h2);
      rd(ADR_REPORT, 32'h0);
      xfer(1'b1, ADR_UNIT, 32'h6);
      rd(ADR_REPORT, 32'(CTRL_RST));
      xfer(1'b1, ADR_UNIT, 32'h0);
      $display("test registers done");
      rnd_en <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         r = {21'h0, 11'($urandom)};
         r[7:6] = 2'(i);
         xfer(1'b1, ADR_CTRL, r);
         rd(ADR_REPORT, r);
         repeat (20) @(posedge clk_i);
      end
      $display("test settings done");
      rnd_en <= 1'b0;
      @(posedge clk_i);
      {bus_active_i, mem_access_i, io_access_i, coproc_access_i} <= 4'h8;
      emulating_i <= 1'b1;
      for (int t = 0; t < N_TIMERS; t++) begin
         xfer(1'b1, ADR_CTRL, 32'h0);
         xfer(1'b1, ADR_FLAGS, 32'hf);
         cond(t, 1'b1);
         repeat (2 * TO + 4) @(posedge clk_i);
         rd(ADR_FLAGS, 32'h0);
         cond(t, 1'b0);
         xfer(1'b1, ADR_CTRL, 32'(1) << (B_BUS_IDLE_TO + t));
         for (int k = 0; k < 3; k++) begin
            cond(t, 1'b1);
            repeat (TO) @(posedge clk_i);
            cond(t, 1'b0);
            @(posedge clk_i);
         end
         cond(t, 1'b1);
         #1 chk("restart", 32'h0, 32'(emu_timeout_o));
         repeat (TO + 1) @(posedge clk_i);
         #1 chk("early", 32'h0, 32'(emu_timeout_o));
         @(posedge clk_i);
         cond(t, 1'b0);
         #1 chk("timeout", 32'h1, 32'(emu_timeout_o));
         rd(ADR_FLAGS, 32'(1) << t);
      end
      $display("test timeouts done");
      test_done();
   end
endmodule : testbench
